//--- dual_timer.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
module dual_timer (
    input  wire logic       core_clk,          // 100 MHz system clock
    input  wire logic       nrst,              // async reset, active low
    input  wire logic [3:0] addr,              // register address
    input  wire logic [7:0] wdata,             // write data
    input  wire logic       wr,                // write strobe
    input  wire logic       rd,                // read strobe
    output logic      [7:0] rdata,             // read data, cycle after rd
    input  wire logic       special_count_clock, // special count source level
    input  wire logic       x_event_pin_in,    // x pin level
    output logic            x_event_pin_out,   // x pin drive level
    output logic            x_event_pin_oe,    // x pin driven in pulse mode
    input  wire logic       y_event_pin_in,    // y pin level
    output logic            y_toggle_output,   // y pin drive level
    output logic            y_event_pin_oe,    // y pin driven when toggling
    output logic            x_irq_flag,        // timer x underflow request
    output logic            y_irq_flag,        // timer y underflow request
    output logic            x_pin_irq_flag,    // x pin edge request
    output logic            y_pin_irq_flag     // y pin edge request
);
    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_s1, rst_n;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and edge history
    logic [7:0] xmode_reg, xmode_next, ymode_reg, ymode_next;
    logic [3:0] flags_reg, flags_next;
    logic [7:0] rdata_next;
    logic [5:0] pre_reg, pre_next;
    logic       xin_reg, yin_reg, sck_reg;
    logic       xout_reg, xout_next, yout_reg, yout_next;
    logic       xoe_next, yoe_next, xoe_reg, yoe_reg;
    logic [1:0] xm, ym;
    logic [2:0] xcs, ycs;
    logic       xedge, yedge;
    logic       x_rise, x_fall, y_rise, y_fall;
    logic       x_sel_edge, y_cnt_edge, y_meas_edge;
    logic       x_src, y_src, x_tick, y_tick, y_reload, y_meas;
    logic       div8, div16, div32, div64;
    logic       x_uf, y_uf;
    logic [15:0] x_cnt, y_cnt, x_view, y_view;
    logic [7:0]  x_shd, y_shd;

    assign xm    = xmode_reg[dual_timer_pkg::MODE_LSB +: 2];
    assign ym    = ymode_reg[dual_timer_pkg::MODE_LSB +: 2];
    assign xcs   = xmode_reg[dual_timer_pkg::CSEL_LSB +: 3];
    assign ycs   = ymode_reg[dual_timer_pkg::CSEL_LSB +: 3];
    assign xedge = xmode_reg[dual_timer_pkg::EDGE_BIT];
    assign yedge = ymode_reg[dual_timer_pkg::EDGE_BIT];

    assign x_rise = x_event_pin_in & ~xin_reg;
    assign x_fall = ~x_event_pin_in & xin_reg;
    assign y_rise = y_event_pin_in & ~yin_reg;
    assign y_fall = ~y_event_pin_in & yin_reg;

    // prescaler: each divided rate is a one-cycle enable
    assign div8  = (pre_reg[2:0] == 3'h7);
    assign div16 = (pre_reg[3:0] == 4'hF);
    assign div32 = (pre_reg[4:0] == 5'h1F);
    assign div64 = (pre_reg == 6'h3F);

    function automatic logic pick(input logic [2:0] cs, input logic d8, input logic d16,
                                  input logic d32, input logic d64, input logic sp);
        logic r;
        r = 1'b0;
        unique case (cs)
            3'h0: r = d8;
            3'h1: r = d16;
            3'h2: r = d32;
            3'h3: r = d64;
            3'h4: r = sp;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb begin
        x_sel_edge = xedge ? x_fall : x_rise;
        x_src = pick(xcs, div8, div16, div32, div64,
                     special_count_clock & ~sck_reg);
        unique case (xm)
            dual_timer_pkg::MODE_EVENT: x_tick = x_sel_edge;
            dual_timer_pkg::MODE_WIDTH:
                x_tick = x_src & (x_event_pin_in ^ xedge);
            default: x_tick = x_src;
        endcase
        if (xmode_reg[dual_timer_pkg::STOP_BIT])
            x_tick = 1'b0;
    end

    always_comb begin
        y_cnt_edge  = yedge ? y_fall : y_rise;
        y_meas_edge = yedge ? y_rise : y_fall;
        // y has no special source: select 4 wraps to divide by 8
        y_src = pick({1'b0, ycs[1:0]}, div8, div16, div32, div64, 1'b0);
        y_meas   = 1'b0;
        y_reload = 1'b0;
        unique case (ym)
            dual_timer_pkg::MODE_PULSE: begin
                y_tick   = y_src;
                y_meas   = 1'b1;
                y_reload = y_meas_edge;
            end
            dual_timer_pkg::MODE_EVENT: y_tick = y_cnt_edge;
            dual_timer_pkg::MODE_WIDTH: begin
                y_tick   = y_src;
                y_meas   = 1'b1;
                y_reload = y_rise | y_fall;
            end
            default: y_tick = y_src;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // counters
    logic xw_lo, xw_hi, yw_lo, yw_hi, xr_lo, xr_hi, yr_lo, yr_hi;
    assign xw_lo = wr & (addr == dual_timer_pkg::ADDR_X_LO);
    assign xw_hi = wr & (addr == dual_timer_pkg::ADDR_X_HI);
    assign yw_lo = wr & (addr == dual_timer_pkg::ADDR_Y_LO);
    assign yw_hi = wr & (addr == dual_timer_pkg::ADDR_Y_HI);
    assign xr_lo = rd & (addr == dual_timer_pkg::ADDR_X_LO);
    assign xr_hi = rd & (addr == dual_timer_pkg::ADDR_X_HI);
    assign yr_lo = rd & (addr == dual_timer_pkg::ADDR_Y_LO);
    assign yr_hi = rd & (addr == dual_timer_pkg::ADDR_Y_HI);

    down_counter16 u_x (
        .clk         (core_clk),
        .rst_n       (rst_n),
        .tick        (x_tick),
        .edge_reload (1'b0),
        .wr_lo       (xw_lo),
        .wr_hi       (xw_hi),
        .wdata       (wdata),
        .latch_only  (xmode_reg[dual_timer_pkg::WCTL_BIT]),
        .hold_cap    (1'b0),
        .rd_hi       (xr_hi),
        .rd_lo       (xr_lo),
        .count       (x_cnt),
        .view        (x_view),
        .lo_shadow   (x_shd),
        .underflow   (x_uf)
    );

    down_counter16 u_y (
        .clk         (core_clk),
        .rst_n       (rst_n),
        .tick        (y_tick),
        .edge_reload (y_reload),
        .wr_lo       (yw_lo),
        .wr_hi       (yw_hi),
        .wdata       (wdata),
        .latch_only  (ymode_reg[dual_timer_pkg::WCTL_BIT]),
        .hold_cap    (y_meas),
        .rd_hi       (yr_hi),
        .rd_lo       (yr_lo),
        .count       (y_cnt),
        .view        (y_view),
        .lo_shadow   (y_shd),
        .underflow   (y_uf)
    );

    ////////////////////////////////////////////////////////////////////////
    // control, flags, toggles, read path
    always_comb begin
        xmode_next = xmode_reg;
        ymode_next = ymode_reg;
        flags_next = flags_reg;
        pre_next   = pre_reg + 6'h01;
        xout_next  = xout_reg;
        yout_next  = yout_reg;
        rdata_next = 8'h00;
        if (wr && addr == dual_timer_pkg::ADDR_FLAGS)
            flags_next = flags_reg & wdata[3:0];    // write zero clears
        if (wr && addr == dual_timer_pkg::ADDR_X_MODE) begin
            xmode_next = wdata;
            xout_next  = ~wdata[dual_timer_pkg::EDGE_BIT];
        end
        if (wr && addr == dual_timer_pkg::ADDR_Y_MODE) begin
            ymode_next = wdata;
            yout_next  = ~wdata[dual_timer_pkg::EDGE_BIT];
        end
        // set wins over a clear in the same cycle
        if (x_uf)
            flags_next[dual_timer_pkg::FLG_XUF] = 1'b1;
        if (y_uf)
            flags_next[dual_timer_pkg::FLG_YUF] = 1'b1;
        if (x_sel_edge)
            flags_next[dual_timer_pkg::FLG_XPIN] = 1'b1;
        if ((ym == dual_timer_pkg::MODE_EVENT || ym == dual_timer_pkg::MODE_TIMER)
            ? y_cnt_edge : y_reload)
            flags_next[dual_timer_pkg::FLG_YPIN] = 1'b1;
        if (x_uf && xm == dual_timer_pkg::MODE_PULSE)
            xout_next = ~xout_reg;
        if (y_uf && ym == dual_timer_pkg::MODE_TIMER && ymode_reg[dual_timer_pkg::YOUT_BIT])
            yout_next = ~yout_reg;
        xoe_next = (xm == dual_timer_pkg::MODE_PULSE);
        yoe_next = (ym == dual_timer_pkg::MODE_TIMER) & ymode_reg[dual_timer_pkg::YOUT_BIT];
        if (rd) begin
            unique case (addr)
                dual_timer_pkg::ADDR_X_LO:   rdata_next = x_shd;
                dual_timer_pkg::ADDR_X_HI:   rdata_next = x_view[15:8];
                dual_timer_pkg::ADDR_Y_LO:   rdata_next = y_shd;
                dual_timer_pkg::ADDR_Y_HI:   rdata_next = y_view[15:8];
                dual_timer_pkg::ADDR_X_MODE: rdata_next = xmode_reg;
                dual_timer_pkg::ADDR_Y_MODE: rdata_next = ymode_reg;
                dual_timer_pkg::ADDR_FLAGS:  rdata_next = {4'h0, flags_reg};
                default:                     rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xmode_reg <= dual_timer_pkg::MODE_RESET;
            ymode_reg <= dual_timer_pkg::MODE_RESET;
            flags_reg <= 4'h0;
            pre_reg   <= 6'h00;
            xin_reg   <= 1'b0;
            yin_reg   <= 1'b0;
            sck_reg   <= 1'b0;
            xout_reg  <= 1'b1;
            yout_reg  <= 1'b1;
            xoe_reg   <= 1'b0;
            yoe_reg   <= 1'b0;
            rdata     <= 8'h00;
        end else begin
            xmode_reg <= xmode_next;
            ymode_reg <= ymode_next;
            flags_reg <= flags_next;
            pre_reg   <= pre_next;
            xin_reg   <= x_event_pin_in;
            yin_reg   <= y_event_pin_in;
            sck_reg   <= special_count_clock;
            xout_reg  <= xout_next;
            yout_reg  <= yout_next;
            xoe_reg   <= xoe_next;
            yoe_reg   <= yoe_next;
            rdata     <= rdata_next;
        end
    end

    assign x_event_pin_out = xout_reg;
    assign x_event_pin_oe  = xoe_reg;
    assign y_toggle_output = yout_reg;
    assign y_event_pin_oe  = yoe_reg;
    assign x_irq_flag      = flags_reg[dual_timer_pkg::FLG_XUF];
    assign y_irq_flag      = flags_reg[dual_timer_pkg::FLG_YUF];
    assign x_pin_irq_flag  = flags_reg[dual_timer_pkg::FLG_XPIN];
    assign y_pin_irq_flag  = flags_reg[dual_timer_pkg::FLG_YPIN];

    ////////////////////////////////////////////////////////////////////////
    // checks
    x_uf_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        x_uf |=> x_irq_flag) else $error("x underflow did not set flag");
    x_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xmode_reg[7] && !xw_hi |=> x_cnt == $past(x_cnt)) else $error("x counted while stopped");
    x_reload_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        x_tick && x_cnt == 16'h0000 && !xw_hi |=> x_uf == 1'b0 && x_cnt == u_x.latch_reg)
        else $error("x reload wrong");
    x_toggle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        x_uf && xm == 2'h1 && !(wr && addr == 4'h4) |=> xout_reg != $past(xout_reg))
        else $error("x pin not toggled");
    y_meas_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        y_reload && !yw_hi |=> y_cnt == $past(u_y.latch_reg) && y_pin_irq_flag)
        else $error("y edge reload wrong");
    y_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        y_reload && y_meas && !yr_lo |=> y_view == $past(y_cnt)) else $error("y capture lost");
    wr_direct_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xw_hi && !xmode_reg[6] |=> x_cnt == {$past(wdata), $past(u_x.wlo_reg)})
        else $error("direct write failed");
    wr_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xw_hi && xmode_reg[6] && !x_tick |=> x_cnt == $past(x_cnt)) else $error("latch write hit counter");
    x_evt_cnt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xm == 2'h2 && x_sel_edge && !xmode_reg[7] && x_cnt != 16'h0 && !xw_hi
        |=> x_cnt == $past(x_cnt) - 16'h1) else $error("x event miscount");
    x_width_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xm == 2'h3 && x_event_pin_in == xedge |-> !x_tick) else $error("x width counted idle");

    x_sp_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xm == 2'h0 && xcs == 3'h4 && !xmode_reg[7] |-> x_tick == (special_count_clock && !sck_reg))
        else $error("x special source wrong");
    x_div_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xm == 2'h0 && xcs < 3'h4 && x_tick |-> pre_reg[2:0] == 3'h7) else $error("x off divider");

    y_div_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ym == 2'h0 && y_tick |-> pre_reg[2:0] == 3'h7) else $error("y off divider");

    x_pin_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        x_sel_edge |=> x_pin_irq_flag) else $error("x pin flag missed");

    y_evt_cnt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ym == 2'h2 && y_cnt_edge && y_cnt != 16'h0 && !yw_hi |=> y_cnt == $past(y_cnt) - 16'h1)
        else $error("y event miscount");
    y_edge_sel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ym == 2'h1 && (yedge ? y_fall : y_rise) |-> !y_reload) else $error("y wrong edge reload");

    y_both_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ym == 2'h3 && (y_rise || y_fall) |-> y_reload) else $error("y edge missed");

    y_toggle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        y_uf && ym == 2'h0 && ymode_reg[7] && !(wr && addr == 4'h5)
        |=> yout_reg != $past(yout_reg)) else $error("y pin not toggled");
    y_oe_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ym != 2'h0 |=> !y_event_pin_oe) else $error("y toggle output in use");

    x_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && addr == 4'h4 && !x_uf |=> xout_reg == !$past(wdata[5])) else $error("x start level");

    y_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && addr == 4'h5 && !y_uf |=> yout_reg == !$past(wdata[5])) else $error("y start level");

    y_uf_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        y_uf |=> y_irq_flag) else $error("y underflow did not set flag");

    y_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        yw_hi && ymode_reg[6] && !y_tick && !y_reload |=> y_cnt == $past(y_cnt))
        else $error("y latch write hit counter");
    y_direct_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        yw_hi && !ymode_reg[6] |=> y_cnt == {$past(wdata), $past(u_y.wlo_reg)})
        else $error("y direct write failed");
    rd_shadow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xr_hi |=> x_shd == $past(x_view[7:0])) else $error("x low byte not captured");

    mode_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd && addr == 4'h4 |=> rdata == $past(xmode_reg)) else $error("mode readback wrong");

    y_hold_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        yr_lo && !y_reload |=> y_view == y_cnt) else $error("y capture not released");

    y_reload_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        y_tick && y_cnt == 16'h0 && !yw_hi && !y_reload |=> y_cnt == u_y.latch_reg)
        else $error("y reload wrong");
endmodule

//--- dual_timer_pkg.sv
package dual_timer_pkg;
    localparam logic [3:0] ADDR_X_LO   = 4'h0;
    localparam logic [3:0] ADDR_X_HI   = 4'h1;
    localparam logic [3:0] ADDR_Y_LO   = 4'h2;
    localparam logic [3:0] ADDR_Y_HI   = 4'h3;
    localparam logic [3:0] ADDR_X_MODE = 4'h4;
    localparam logic [3:0] ADDR_Y_MODE = 4'h5;
    localparam logic [3:0] ADDR_FLAGS  = 4'h6;
    // mode register fields
    localparam int MODE_LSB  = 0;
    localparam int CSEL_LSB  = 2;
    localparam int EDGE_BIT  = 5;
    localparam int WCTL_BIT  = 6;
    localparam int STOP_BIT  = 7;
    localparam int YOUT_BIT  = 7;
    // flags register bits
    localparam int FLG_XUF   = 0;
    localparam int FLG_YUF   = 1;
    localparam int FLG_XPIN  = 2;
    localparam int FLG_YPIN  = 3;
    localparam logic [7:0]  MODE_RESET  = 8'h00;
    localparam logic [15:0] CNT_RESET   = 16'hFFFF;
    // clock selects: 0..3 are divide by 8,16,32,64; 4 is the special clock for x, divide by 8 for y
    localparam logic [2:0]  CSEL_SPECIAL = 3'h4;
    localparam int          PRESCALE_W  = 6;
    typedef enum logic [1:0] {
        MODE_TIMER  = 2'h0,
        MODE_PULSE  = 2'h1,
        MODE_EVENT  = 2'h2,
        MODE_WIDTH  = 2'h3
    } timer_mode_e;
endpackage

//--- down_counter16.sv
`timescale 1ns/10ps
module down_counter16 (
    input  wire logic        clk,          // system clock
    input  wire logic        rst_n,        // synchronised reset
    input  wire logic        tick,         // count pulse
    input  wire logic        edge_reload,  // forced reload from latch
    input  wire logic        wr_lo,        // low byte written (staged)
    input  wire logic        wr_hi,        // high byte written, commits word
    input  wire logic [7:0]  wdata,        // write byte
    input  wire logic        latch_only,   // write control bit
    input  wire logic        hold_cap,     // keep captured value on edge reload
    input  wire logic        rd_hi,        // high byte read
    input  wire logic        rd_lo,        // low byte read
    output logic      [15:0] count,        // live count
    output logic      [15:0] view,         // value software sees
    output logic      [7:0]  lo_shadow,    // low byte captured at high read
    output logic             underflow     // one-cycle underflow pulse
);
    logic [15:0] count_reg, count_next, latch_reg, latch_next, cap_reg, cap_next;
    logic [7:0]  wlo_reg, wlo_next, shd_reg, shd_next;
    logic        held_reg, held_next;
    logic [15:0] word;

    always_comb begin
        word       = {wdata, wlo_reg};
        count_next = count_reg;
        latch_next = latch_reg;
        cap_next   = cap_reg;
        held_next  = held_reg;
        wlo_next   = wr_lo ? wdata : wlo_reg;
        shd_next   = rd_hi ? view[7:0] : shd_reg;
        underflow  = 1'b0;
        if (rd_lo)
            held_next = 1'b0;
        if (edge_reload) begin
            cap_next   = count_reg;
            held_next  = hold_cap;
            count_next = latch_reg;
        end else if (tick) begin
            if (count_reg == 16'h0000) begin
                count_next = latch_reg;
                underflow  = 1'b1;
            end else begin
                count_next = count_reg - 16'h0001;
            end
        end
        if (wr_hi) begin
            latch_next = word;
            if (!latch_only)
                count_next = word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= dual_timer_pkg::CNT_RESET;
            latch_reg <= dual_timer_pkg::CNT_RESET;
            cap_reg   <= 16'h0000;
            held_reg  <= 1'b0;
            wlo_reg   <= 8'h00;
            shd_reg   <= 8'h00;
        end else begin
            count_reg <= count_next;
            latch_reg <= latch_next;
            cap_reg   <= cap_next;
            held_reg  <= held_next;
            wlo_reg   <= wlo_next;
            shd_reg   <= shd_next;
        end
    end

    assign count     = count_reg;
    assign view      = held_reg ? cap_reg : count_reg;
    assign lo_shadow = shd_reg;
endmodule

//--- pin_model.sv
`timescale 1ns/10ps
module pin_model (
    input  wire logic clk,    // system clock
    output logic      x_lvl,  // x pin level while timer x is not driving
    output logic      y_lvl,  // y pin level
    output logic      sp_clk  // special count source
);
    initial begin
        x_lvl  = 1'b0;
        y_lvl  = 1'b0;
        sp_clk = 1'b0;
    end
    // free-running source at half the core rate
    always @(posedge clk) begin
        sp_clk <= ~sp_clk;
    end
    // each pulse is two cycles high, two low: wide enough for edge sampling
    task automatic x_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (2) @(posedge clk);
            x_lvl <= 1'b1;
            repeat (2) @(posedge clk);
            x_lvl <= 1'b0;
        end
    endtask
    task automatic y_set(input logic v);
        repeat (2) @(posedge clk);
        y_lvl <= v;
    endtask
endmodule

//--- tb_dual_timer.sv
`timescale 1ns/10ps
module tb_dual_timer;
    logic       core_clk, nrst, wr, rd, x_out, x_oe, y_out, y_oe;
    logic       x_lvl, y_lvl, sp_clk, x_irq, y_irq, xp_irq, yp_irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [15:0] v;
    int         n_mismatch, n_tests;
    wire        x_pin = x_oe ? x_out : x_lvl;
    wire        y_pin = y_oe ? y_out : y_lvl;
    ////////////////////////////////////////////////////////////////
    dual_timer i_dut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .special_count_clock(sp_clk), .x_event_pin_in(x_pin),
        .x_event_pin_out(x_out), .x_event_pin_oe(x_oe), .y_event_pin_in(y_pin),
        .y_toggle_output(y_out), .y_event_pin_oe(y_oe), .x_irq_flag(x_irq),
        .y_irq_flag(y_irq), .x_pin_irq_flag(xp_irq), .y_pin_irq_flag(yp_irq));
    pin_model i_pins (.clk(core_clk), .x_lvl(x_lvl), .y_lvl(y_lvl), .sp_clk(sp_clk));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    // low byte first, high byte commits the word
    task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
        wr_reg(lo, d[7:0]);
        wr_reg(lo + 4'h1, d[15:8]);
    endtask
    // high byte first, low byte comes from the capture
    task automatic rd16(input logic [3:0] lo, output logic [15:0] d);
        rd_reg(lo + 4'h1, d[15:8]);
        rd_reg(lo, d[7:0]);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] b;
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk(v, 16'hFFFF);
        rd_reg(dual_timer_pkg::ADDR_X_MODE, b);
        chk({8'h00, b}, 16'h0000);
        rd_reg(4'hF, b);
        chk({8'h00, b}, 16'h0000);
    endtask
    task automatic t_stop();
        wr_reg(dual_timer_pkg::ADDR_X_MODE, 8'h80);
        wr16(dual_timer_pkg::ADDR_X_LO, 16'h0005);
        repeat (100) @(posedge core_clk);
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk(v, 16'h0005);
        chk({15'h0, x_irq}, 16'h0000);
        wr_reg(dual_timer_pkg::ADDR_X_MODE, 8'h00);
        repeat (100) @(posedge core_clk);
        wr_reg(dual_timer_pkg::ADDR_X_MODE, 8'h80);
        chk({15'h0, x_irq}, 16'h0001);
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk({15'h0, v <= 16'h0005}, 16'h0001);
        wr_reg(dual_timer_pkg::ADDR_FLAGS, 8'h00);
        chk({15'h0, x_irq}, 16'h0000);
    endtask
    task automatic t_event();
        wr_reg(dual_timer_pkg::ADDR_X_MODE, 8'h02);
        wr16(dual_timer_pkg::ADDR_X_LO, 16'h0002);
        i_pins.x_pulses(2);
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk(v, 16'h0000);
        i_pins.x_pulses(1);
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk(v, 16'h0002);
        chk({14'h0, x_irq, xp_irq}, 16'h0003);
        // falling edges only: one pulse is one count
        wr_reg(dual_timer_pkg::ADDR_X_MODE, 8'h22);
        wr16(dual_timer_pkg::ADDR_X_LO, 16'h0003);
        i_pins.x_pulses(1);
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk(v, 16'h0002);
        wr_reg(dual_timer_pkg::ADDR_X_MODE, 8'h42);
        wr16(dual_timer_pkg::ADDR_X_LO, 16'h0007);
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk(v, 16'h0002);
        i_pins.x_pulses(3);
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk(v, 16'h0007);
    endtask
    // width mode on the special source: one count per two-cycle high pulse
    task automatic t_width();
        wr_reg(dual_timer_pkg::ADDR_X_MODE, 8'h13);
        wr16(dual_timer_pkg::ADDR_X_LO, 16'h0100);
        i_pins.x_pulses(2);
        rd16(dual_timer_pkg::ADDR_X_LO, v);
        chk(v, 16'h00FE);
    endtask
    // toggle output of one timer, both start levels
    task automatic t_toggle(input bit y);
        logic [3:0] ma;
        logic [7:0] mv;
        logic       s;
        int         k;
        logic [3:0] la;
        ma = y ? dual_timer_pkg::ADDR_Y_MODE : dual_timer_pkg::ADDR_X_MODE;
        la = y ? dual_timer_pkg::ADDR_Y_LO : dual_timer_pkg::ADDR_X_LO;
        for (int e = 0; e < 2; e++) begin
            mv = y ? {2'b10, e[0], 5'h00} : {2'b00, e[0], 5'h01};
            // park the count high so no underflow moves the level before the check
            wr16(la, 16'hFFFF);
            wr_reg(ma, mv);
            wr16(la, 16'h0000);
            s = y ? y_out : x_out;
            chk({14'h0, y ? y_oe : x_oe, s}, {14'h0, 1'b1, ~e[0]});
            k = 0;
            while ((y ? y_out : x_out) === s && k < 40) begin
                @(posedge core_clk);
                k++;
            end
            chk({15'h0, (y ? y_out : x_out) === ~s}, 16'h0001);
            chk({15'h0, y ? y_irq : x_irq}, 16'h0001);
        end
    endtask
    task automatic t_period();
        wr_reg(dual_timer_pkg::ADDR_Y_MODE, 8'h21);
        wr16(dual_timer_pkg::ADDR_Y_LO, 16'h0100);
        wr_reg(dual_timer_pkg::ADDR_FLAGS, 8'h00);
        repeat (400) @(posedge core_clk);
        i_pins.y_set(1'b1);
        repeat (3) @(posedge core_clk);
        chk({15'h0, yp_irq}, 16'h0001);
        repeat (200) @(posedge core_clk);
        rd16(dual_timer_pkg::ADDR_Y_LO, v);
        chk({15'h0, v < 16'h00E0}, 16'h0001);
        rd16(dual_timer_pkg::ADDR_Y_LO, v);
        chk({15'h0, v >= 16'h00E0}, 16'h0001);
        wr_reg(dual_timer_pkg::ADDR_FLAGS, 8'h00);
        i_pins.y_set(1'b0);
        repeat (3) @(posedge core_clk);
        chk({15'h0, yp_irq}, 16'h0000);
        wr_reg(dual_timer_pkg::ADDR_Y_MODE, 8'h23);
        i_pins.y_set(1'b1);
        i_pins.y_set(1'b0);
        repeat (3) @(posedge core_clk);
        chk({15'h0, yp_irq}, 16'h0001);
        // the width capture stays shown until one read releases it
        rd16(dual_timer_pkg::ADDR_Y_LO, v);
        wr_reg(dual_timer_pkg::ADDR_Y_MODE, 8'h02);
        wr16(dual_timer_pkg::ADDR_Y_LO, 16'h0005);
        i_pins.y_set(1'b1);
        i_pins.y_set(1'b0);
        rd16(dual_timer_pkg::ADDR_Y_LO, v);
        chk(v, 16'h0004);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
    initial begin
        {nrst, wr, rd, addr, wdata, n_mismatch, n_tests} = '0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_reset();
        t_stop();
        t_event();
        t_width();
        t_toggle(1'b0);
        t_toggle(1'b1);
        t_period();
        close_out();
    end
endmodule
